// >>> rtl/ddr_burst_pkg.sv
/*
  Shared constants and types for the double-data-rate SRAM control block:
  operation encodings, the sampled pin group and reset values.
  Assumes all users refer to items as ddr_burst_pkg::name.
*/
package ddr_burst_pkg;

  // Burst geometry: four internal word addresses per external address
  localparam int BURST_LEN = 4;
  localparam int ECHO_PAIRS = 2;

  // Position of the word-select bit inside a full internal address
  localparam int ADDR_LSB_POS = 0;
  localparam logic ADDR_LSB_RISE = 1'b0;
  localparam logic ADDR_LSB_FALL = 1'b1;

  // Reset values of the output stage and the helper continue counter
  localparam logic DQ_OE_RESET = 1'b0;
  localparam logic ECHO_OE_RESET = 1'b0;
  localparam logic ECHO_RESET = 1'b0;
  localparam logic [1:0] CONT_CNT_RESET = 2'h0;

  // Operation that governs the data and echo pins one cycle later
  typedef enum logic [1:0] {
    OP_BANK_DESEL,
    OP_DESEL,
    OP_READ,
    OP_WRITE
  } op_type;

  localparam op_type OP_RESET = OP_BANK_DESEL;

  // Control pins, sampled together through the synchroniser
  typedef struct packed {
    logic main_clock;
    logic primary_select_n;
    logic prog_select_a;
    logic prog_select_b;
    logic polarity_sel_a;
    logic polarity_sel_b;
    logic advance_load_n;
    logic write_n;
  } pins_type;

  localparam pins_type PINS_RESET = '{
    main_clock: 1'b0,
    primary_select_n: 1'b1,
    prog_select_a: 1'b0,
    prog_select_b: 1'b0,
    polarity_sel_a: 1'b1,
    polarity_sel_b: 1'b1,
    advance_load_n: 1'b1,
    write_n: 1'b1
  };

endpackage

// >>> rtl/ddr_sram_burst_echo_control.sv
/*
  Control logic of a double-data-rate synchronous SRAM: command decode,
  two-bit linear burst counter, bank enables with programmable polarity,
  pipelined tri-state control of data and echo clocks, plus a small array.
  Assumes main_clock_i and every pin arrive from outside the clk_i domain,
  with main_clock_i much slower than clk_i (several clk_i cycles per half).
*/
// Summary of operation
// - Advance/load high after a read or write steps the burst counter and accesses its address.
// - Advance/load low on a rising edge loads the presented start address.
// - Counter returns to its start after four internal addresses.
// - Low two address bits count linearly modulo four from start.
// - Word bit forced 0 on rising transfer, 1 on following falling one.
// - Counter back at its initial state on the third rising edge.
// - One continue cycle after read or write advances address by two.
// - A second continue wraps the address back to the loaded base.
// - Two true and two inverted echo clocks follow clock with data.
// - Bank deselect turns echo clocks off with the data pipeline delay.
// - Primary enable deselect alone leaves the echo clocks running.
// - Each programmable enable's active level follows its polarity pin.
// - Bank enable true only when both enables match their polarity pins.
// - Echo clocks float one cycle after a bank deselect command only.
// - Data pins float one cycle after bank deselect, deselect or write.
// - Pins in the command cycle are governed by the previous operation.
// - Write needs all enables active, write low and advance/load low.
// - Write data taken both edges from the rising edge after command.
// - Read data given on the next rising and then the falling edge.
// - Device becomes active only on a load with all three chip enables asserted; continues ignore them.
`timescale 1ns/1ns
module ddr_sram_burst_echo_control #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 18
) (
  input wire logic clk_i, // System clock, 20 MHz
  input wire logic reset_n_i, // Synchronous reset, active low
  input wire logic ce_i, // Clock enable, freezes all state when low
  input wire logic main_clock_i, // Memory clock from the controller
  input wire logic primary_select_n_i, // Primary chip enable, active low
  input wire logic prog_select_a_i, // Programmable enable A
  input wire logic prog_select_b_i, // Programmable enable B
  input wire logic polarity_sel_a_i, // Active level of enable A
  input wire logic polarity_sel_b_i, // Active level of enable B
  input wire logic advance_load_n_i, // High advances, low loads address
  input wire logic write_n_i, // Write enable, active low
  input wire logic [ADDR_W-1:0] addr_i, // External address, no word bit
  input wire logic [DATA_W-1:0] dq_i, // Data pin input side
  output logic [DATA_W-1:0] dq_o, // Data pin output side
  output logic dq_oe_o, // Data pin output enable
  output logic echo_clk_true_0_o, // Echo clock 0, in phase
  output logic echo_clk_true_1_o, // Echo clock 1, in phase
  output logic echo_clk_inv_0_o, // Echo clock 0, inverted
  output logic echo_clk_inv_1_o, // Echo clock 1, inverted
  output logic echo_oe_o // Echo clock output enable
);

  localparam int WORD_W = ADDR_W + 1;

  // Synchroniser stages and edge finder
  ddr_burst_pkg::pins_type pins_now;
  ddr_burst_pkg::pins_type pin_meta_r;
  ddr_burst_pkg::pins_type pin_sync_r;
  logic [ADDR_W-1:0] addr_meta_r;
  logic [ADDR_W-1:0] addr_sync_r;
  logic [DATA_W-1:0] dq_meta_r;
  logic [DATA_W-1:0] dq_sync_r;
  logic clk_prev_r;

  // Command and data-phase state
  ddr_burst_pkg::op_type cur_op_r;
  ddr_burst_pkg::op_type op_nxt;
  ddr_burst_pkg::op_type phase_op_r;
  logic [ADDR_W-1:0] cur_addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [ADDR_W-1:0] phase_addr_r;
  logic [ddr_burst_pkg::ECHO_PAIRS-1:0] echo_true_r;
  logic [ddr_burst_pkg::ECHO_PAIRS-1:0] echo_inv_r;

  // Storage array
  logic [DATA_W-1:0] mem [0:(1<<WORD_W)-1];

  // Decode wires
  wire clk_rise;
  wire clk_fall;
  wire bank_en;
  wire is_load;
  wire cur_is_access;
  wire [WORD_W-1:0] even_idx;
  wire [WORD_W-1:0] odd_idx;
  wire [DATA_W-1:0] even_data;
  wire [DATA_W-1:0] odd_data;

  assign pins_now = '{
    main_clock: main_clock_i,
    primary_select_n: primary_select_n_i,
    prog_select_a: prog_select_a_i,
    prog_select_b: prog_select_b_i,
    polarity_sel_a: polarity_sel_a_i,
    polarity_sel_b: polarity_sel_b_i,
    advance_load_n: advance_load_n_i,
    write_n: write_n_i
  };

  assign clk_rise = pin_sync_r.main_clock & ~clk_prev_r;
  assign clk_fall = ~pin_sync_r.main_clock & clk_prev_r;

  // Each enable is active at the level its polarity pin is tied to
  assign bank_en = (pin_sync_r.prog_select_a == pin_sync_r.polarity_sel_a)
    && (pin_sync_r.prog_select_b == pin_sync_r.polarity_sel_b);
  assign is_load = ~pin_sync_r.advance_load_n;
  assign cur_is_access = (cur_op_r == ddr_burst_pkg::OP_READ) ||
    (cur_op_r == ddr_burst_pkg::OP_WRITE);

  // Load decodes a new command; continue keeps the current one
  assign op_nxt = !is_load ? cur_op_r :
    !bank_en ? ddr_burst_pkg::OP_BANK_DESEL :
    pin_sync_r.primary_select_n ? ddr_burst_pkg::OP_DESEL :
    pin_sync_r.write_n ? ddr_burst_pkg::OP_READ :
    ddr_burst_pkg::OP_WRITE;

  // Continue during a read or write toggles bit one of the full address: a step of two, mod four
  assign addr_nxt = is_load ? addr_sync_r :
    {cur_addr_r[ADDR_W-1:1], cur_addr_r[0] ^ cur_is_access};

  // Word bit is forced per half-cycle and never taken from the pins
  assign even_idx = {cur_addr_r, ddr_burst_pkg::ADDR_LSB_RISE};
  assign odd_idx = {phase_addr_r, ddr_burst_pkg::ADDR_LSB_FALL};
  assign even_data = mem[even_idx];
  assign odd_data = mem[odd_idx];

  assign echo_clk_true_0_o = echo_true_r[0];
  assign echo_clk_true_1_o = echo_true_r[1];
  assign echo_clk_inv_0_o = echo_inv_r[0];
  assign echo_clk_inv_1_o = echo_inv_r[1];

  // Two-flop synchroniser for all pins; third stage only for the edge
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_meta_r <= ddr_burst_pkg::PINS_RESET;
      pin_sync_r <= ddr_burst_pkg::PINS_RESET;
      clk_prev_r <= 1'b0;
    end else if (ce_i) begin
      pin_meta_r <= pins_now;
      pin_sync_r <= pin_meta_r;
      clk_prev_r <= pin_sync_r.main_clock;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      addr_meta_r <= '0;
      addr_sync_r <= '0;
      dq_meta_r <= '0;
      dq_sync_r <= '0;
    end else if (ce_i) begin
      addr_meta_r <= addr_i;
      addr_sync_r <= addr_meta_r;
      dq_meta_r <= dq_i;
      dq_sync_r <= dq_meta_r;
    end
  end

  // Command sampled on each rising edge; the previous one moves to the
  // data phase so the pins lag the command by one full cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cur_op_r <= ddr_burst_pkg::OP_RESET;
      cur_addr_r <= '0;
      phase_op_r <= ddr_burst_pkg::OP_RESET;
      phase_addr_r <= '0;
    end else if (ce_i && clk_rise) begin
      cur_op_r <= op_nxt;
      cur_addr_r <= addr_nxt;
      phase_op_r <= cur_op_r;
      phase_addr_r <= cur_addr_r;
    end
  end

  // Output enables follow the operation sampled one rising edge earlier
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dq_oe_o <= ddr_burst_pkg::DQ_OE_RESET;
      echo_oe_o <= ddr_burst_pkg::ECHO_OE_RESET;
    end else if (ce_i && clk_rise) begin
      dq_oe_o <= (cur_op_r == ddr_burst_pkg::OP_READ);
      echo_oe_o <= (cur_op_r !=
        ddr_burst_pkg::OP_BANK_DESEL);
    end
  end

  // Read data: even word at the rising edge, odd word at the falling edge
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dq_o <= '0;
    end else if (ce_i) begin
      if (clk_rise && cur_op_r == ddr_burst_pkg::OP_READ) begin
        dq_o <= even_data;
      end else if (clk_fall && phase_op_r == ddr_burst_pkg::OP_READ) begin
        dq_o <= odd_data;
      end
    end
  end

  // Write data: captured on both edges of the cycle after the command
  always_ff @(posedge clk_i) begin
    if (ce_i && reset_n_i) begin
      if (clk_rise && cur_op_r == ddr_burst_pkg::OP_WRITE) begin
        mem[even_idx] <= dq_sync_r;
      end
      if (clk_fall && phase_op_r == ddr_burst_pkg::OP_WRITE) begin
        mem[odd_idx] <= dq_sync_r;
      end
    end
  end

  // Echo clocks are registered copies of the sampled clock, so they move
  // in the same cycle as the data register
  for (genvar g = 0; g < ddr_burst_pkg::ECHO_PAIRS; g++) begin : g_echo
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        echo_true_r[g] <= ddr_burst_pkg::ECHO_RESET;
        echo_inv_r[g] <= ~ddr_burst_pkg::ECHO_RESET;
      end else if (ce_i) begin
        echo_true_r[g] <= pin_sync_r.main_clock;
        echo_inv_r[g] <= ~pin_sync_r.main_clock;
      end
    end
  end

  // Helper state for checks: loaded base and continues since load
  logic [ADDR_W-1:0] base_r;
  logic [1:0] cont_cnt_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      base_r <= '0;
      cont_cnt_r <= ddr_burst_pkg::CONT_CNT_RESET;
    end else if (ce_i && clk_rise) begin
      if (is_load) begin
        base_r <= addr_sync_r;
        cont_cnt_r <= ddr_burst_pkg::CONT_CNT_RESET;
      end else begin
        cont_cnt_r <= cont_cnt_r + 2'h1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i || !ce_i);

  sequence s_load;
    clk_rise && is_load;
  endsequence

  sequence s_continue;
    clk_rise && !is_load;
  endsequence

  sequence s_access_load;
    clk_rise && is_load && bank_en && !pin_sync_r.primary_select_n;
  endsequence

  property p_load_addr;
    s_load |=> cur_addr_r == $past(addr_sync_r);
  endproperty
  a_load_addr: assert property (p_load_addr)
    else $error("start address not loaded on load cycle");

  property p_advance;
    s_continue ##0 cur_is_access |=>
      cur_addr_r == ($past(cur_addr_r) ^ {{(ADDR_W-1){1'b0}}, 1'b1});
  endproperty
  a_advance: assert property (p_advance)
    else $error("continue did not advance the address by two");

  property p_wrap_base;
    cur_is_access && !cont_cnt_r[0] |-> cur_addr_r == base_r;
  endproperty
  a_wrap_base: assert property (p_wrap_base)
    else $error("burst did not wrap back to the loaded base");

  property p_odd_step;
    cur_is_access && cont_cnt_r[0] |->
      cur_addr_r == (base_r ^ {{(ADDR_W-1){1'b0}}, 1'b1});
  endproperty
  a_odd_step: assert property (p_odd_step)
    else $error("burst address not two past the base after one continue");

  property p_bank_desel;
    s_load ##0 !bank_en |=> cur_op_r == ddr_burst_pkg::OP_BANK_DESEL;
  endproperty
  a_bank_desel: assert property (p_bank_desel)
    else $error("mismatched programmable enable did not deselect bank");

  property p_polarity;
    s_load ##0 (pin_sync_r.prog_select_a != pin_sync_r.polarity_sel_a)
      |=> cur_op_r == ddr_burst_pkg::OP_BANK_DESEL;
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("enable A active at the wrong level");

  property p_primary;
    s_load ##0 bank_en && pin_sync_r.primary_select_n
      |=> cur_op_r == ddr_burst_pkg::OP_DESEL;
  endproperty
  a_primary: assert property (p_primary)
    else $error("primary enable high did not deselect");

  property p_write_cmd;
    s_access_load ##0 !pin_sync_r.write_n
      |=> cur_op_r == ddr_burst_pkg::OP_WRITE;
  endproperty
  a_write_cmd: assert property (p_write_cmd)
    else $error("write command not recognised");

  property p_cont_keep;
    s_continue ##0 !cur_is_access |=> $stable(cur_op_r);
  endproperty
  a_cont_keep: assert property (p_cont_keep)
    else $error("continue left the deselected state");

  property p_echo_off;
    clk_rise && cur_op_r == ddr_burst_pkg::OP_BANK_DESEL |=> !echo_oe_o;
  endproperty
  a_echo_off: assert property (p_echo_off)
    else $error("echo clocks still driven after bank deselect");

  property p_echo_on_desel;
    clk_rise && cur_op_r == ddr_burst_pkg::OP_DESEL |=> echo_oe_o;
  endproperty
  a_echo_on_desel: assert property (p_echo_on_desel)
    else $error("primary deselect stopped the echo clocks");

  property p_dq_float;
    clk_rise && cur_op_r != ddr_burst_pkg::OP_READ |=> !dq_oe_o;
  endproperty
  a_dq_float: assert property (p_dq_float)
    else $error("data pins driven outside a read phase");

  property p_hold;
    !clk_rise |=> $stable(dq_oe_o) && $stable(echo_oe_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pin enables changed away from a rising edge");

  property p_echo_track;
    clk_rise |=> echo_clk_true_0_o && echo_clk_true_1_o &&
      !echo_clk_inv_0_o && !echo_clk_inv_1_o;
  endproperty
  a_echo_track: assert property (p_echo_track)
    else $error("echo clocks do not follow the memory clock");

  property p_read_even;
    clk_rise && cur_op_r == ddr_burst_pkg::OP_READ |=>
      dq_oe_o && dq_o == $past(even_data);
  endproperty
  a_read_even: assert property (p_read_even)
    else $error("rising read word not from the even address");

  property p_write_even;
    clk_rise && cur_op_r == ddr_burst_pkg::OP_WRITE |=>
      mem[$past(even_idx)] == $past(dq_sync_r);
  endproperty
  a_write_even: assert property (p_write_even)
    else $error("rising write word not stored");

endmodule // ddr_sram_burst_echo_control

// >>> testbench/mem_ctrl_model.sv
/*
  Behavioural model of the memory controller that faces the SRAM control
  block: makes the memory clock, drives command pins, address and data.
  Assumes the bench calls cycle() 13 ns after a clk_i rising edge.
*/
`timescale 1ns/1ns
module mem_ctrl_model (
  output logic main_clock_o, // Memory clock, still outside cycles
  output ddr_burst_pkg::pins_type cmd_o, // Command pins
  output logic [7:0] addr_o, // External address
  output logic [17:0] dq_o, // Data towards the device
  input wire logic [23:0] view_i // Device outputs, sampled
);
  initial begin
    main_clock_o = 1'b0;
    cmd_o = ddr_burst_pkg::PINS_RESET;
    addr_o = 8'h00;
    dq_o = 18'h2aaaa;
  end

  // One memory clock period of 400 ns; pins settle 100 ns before the rise
  task automatic cycle(input ddr_burst_pkg::pins_type cmd,
    input logic [7:0] addr, input logic wr_en, input logic [17:0] wr,
    input logic [17:0] wf, output logic [23:0] seen_f,
    output logic [23:0] seen_r);
    cmd_o = cmd;
    addr_o = addr;
    // Data line not in use shows a changing pattern
    dq_o = wr_en ? wr : ~dq_o;
    #100 main_clock_o = 1'b1;
    #100 seen_f = view_i;
    dq_o = wr_en ? wf : ~dq_o;
    #100 main_clock_o = 1'b0;
    #100 seen_r = view_i;
  endtask
endmodule // mem_ctrl_model

// >>> testbench/testbench.sv
/*
  Self-checking bench for the SRAM control block: burst write and read
  with wrap-around, deselect kinds and all bank polarity combinations.
  Assumes the controller model of mem_ctrl_model.sv beside it.
*/
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] BASE = 8'h35;
  // Command codes: {e1_n, sel_a, sel_b, pol_a, pol_b, adv_n, write_n}
  localparam logic [6:0] LD_WR = 7'h3c;
  localparam logic [6:0] LD_RD = 7'h3d;
  localparam logic [6:0] CONT = 7'h3e;
  localparam logic [6:0] DESEL = 7'h7d;

  logic clk_i;
  logic reset_n_i;
  logic main_clock;
  ddr_burst_pkg::pins_type cmd;
  logic [7:0] addr;
  logic [17:0] dq_in;
  logic [17:0] dq_out;
  logic dq_oe, echo_oe, et0, et1, ei0, ei1;
  logic [23:0] sf, sr;
  logic [17:0] w [4];
  int failures;
  int checked;

  ddr_sram_burst_echo_control i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .main_clock_i(main_clock),
    .primary_select_n_i(cmd.primary_select_n),
    .prog_select_a_i(cmd.prog_select_a),
    .prog_select_b_i(cmd.prog_select_b),
    .polarity_sel_a_i(cmd.polarity_sel_a),
    .polarity_sel_b_i(cmd.polarity_sel_b),
    .advance_load_n_i(cmd.advance_load_n), .write_n_i(cmd.write_n),
    .addr_i(addr), .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_oe),
    .echo_clk_true_0_o(et0), .echo_clk_true_1_o(et1),
    .echo_clk_inv_0_o(ei0), .echo_clk_inv_1_o(ei1), .echo_oe_o(echo_oe)
  );

  mem_ctrl_model i_ctrl (
    .main_clock_o(main_clock), .cmd_o(cmd), .addr_o(addr), .dq_o(dq_in),
    .view_i({dq_oe, echo_oe, et0, et1, ei0, ei1, dq_out})
  );

  task automatic check(input string what, input logic [23:0] seen,
    input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One memory cycle with the command f and write data for the last one
  task automatic step(input logic [6:0] f, input logic wen,
    input logic [17:0] wr, input logic [17:0] wf);
    i_ctrl.cycle(ddr_burst_pkg::pins_type'({1'b0, f}), BASE, wen, wr, wf,
      sf, sr);
  endtask

  // Data is compared only where the pins should be driven
  task automatic expect_at(input string what, input logic rise,
    input logic oe, input logic eoe, input logic [17:0] dq);
    logic [23:0] s;
    s = rise ? sr : sf;
    if (!oe) s[17:0] = 18'h0;
    check(what, s, {oe, eoe, rise ? 4'hc : 4'h3, oe ? dq : 18'h0});
  endtask

  task automatic sc_burst();
    step(LD_WR, 1'b0, 18'h0, 18'h0);
    step(CONT, 1'b1, w[0], w[1]);
    expect_at("write load", 1, 0, 1, 0);
    step(DESEL, 1'b1, w[2], w[3]);
    expect_at("write continue", 1, 0, 1, 0);
    step(LD_RD, 1'b0, 18'h0, 18'h0);
    expect_at("primary deselect", 1, 0, 1, 0);
    step(CONT, 1'b0, 18'h0, 18'h0);
    expect_at("read word 0", 1, 1, 1, w[0]);
    step(CONT, 1'b0, 18'h0, 18'h0);
    expect_at("read word 1", 0, 1, 1, w[1]);
    expect_at("read word 2", 1, 1, 1, w[2]);
    step(DESEL, 1'b0, 18'h0, 18'h0);
    expect_at("read word 3", 0, 1, 1, w[3]);
    expect_at("wrapped word 0", 1, 1, 1, w[0]);
    step(CONT, 1'b0, 18'h0, 18'h0);
    expect_at("previous op", 0, 1, 1, w[1]);
    expect_at("deselected", 1, 0, 1, 0);
    step(CONT, 1'b0, 18'h0, 18'h0);
    expect_at("deselect continue", 1, 0, 1, 0);
  endtask

  task automatic sc_banks();
    logic [6:0] f;
    logic hit;
    for (int i = 0; i < 16; i++) begin
      f = {1'b0, i[1:0], i[3:2], 2'b01};
      hit = (i[1:0] == i[3:2]);
      step(f, 1'b0, 18'h0, 18'h0);
      step(f | 7'h02, 1'b0, 18'h0, 18'h0);
      expect_at("bank select", 1, hit, hit, w[0]);
      step(f | 7'h02, 1'b0, 18'h0, 18'h0);
      expect_at("bank continue", 1, hit, hit, w[2]);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    failures = 0;
    checked = 0;
    reset_n_i = 1'b0;
    w[0] = 18'h0a5a1;
    w[1] = 18'h35a5e;
    w[2] = 18'h0f0f3;
    w[3] = 18'h3c3cc;
    repeat (12) @(posedge clk_i);
    #13 reset_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #13;
    sc_burst();
    sc_banks();
    report_and_stop();
  end
endmodule // testbench
